// File: core/xdata_defines.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * external data access block.
 * Assumes an 8-bit special-function address space and a 4-clock machine cycle.
 */
`ifndef XDATA_DEFINES_VH
`define XDATA_DEFINES_VH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define ADDR_DP_LOW        8'h82
`define ADDR_DP_HIGH       8'h83
`define ADDR_PTR_SELECT    8'h86
`define ADDR_TIMING_CTRL   8'h8E
`define ADDR_STATUS        8'h8F
`define ADDR_PORT2_LATCH   8'hA0
`define ADDR_BANK_SELECT   8'hD0
`define WREG_SPACE_TOP     8'h1F

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PTR_SELECT_BIT     0
`define STRETCH_MSB        2
`define STRETCH_LSB        0
`define BANK_MSB           4
`define BANK_LSB           3
`define STATUS_BUSY_BIT    0
`define STATUS_HOLD_BIT    1

// ---------------------------------------------------------------------------
// reset values and stretch field width
// ---------------------------------------------------------------------------
`define TIMING_CTRL_RESET  8'h01
`define PORT2_RESET        8'hFF
`define STRETCH_WIDTH      3

// ---------------------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------------------
`define CLOCKS_PER_MCYCLE  5'd4
`define STROBE_CLOCKS_S0   5'd2
`define STROBE_START_S0    5'd1
`define STROBE_START       5'd2

`endif

// File: core/working_reg_mem.v
/*
 * Working register storage: four banks of eight bytes, one write port and
 * one read port whose data come out of a register.
 * Assumes a single clock; the clock enable freezes the read register too.
 */
`timescale 1ns/1ns
module working_reg_mem (
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire we_i,
   input wire [4:0] waddr_i,
   input wire [7:0] wdata_i,
   input wire [4:0] raddr_i,
   output reg [7:0] rdata_o
);
   reg [7:0] mem [0:31];

   always @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // write-through so a register written just before a move is seen
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
         end else begin
            rdata_o <= mem[raddr_i];
         end
      end
   end
endmodule // working_reg_mem

// File: core/external_data_access_stretch.v
/*
 * External data move path: address forming from an indexed working register
 * and the port 2 latch or from one of two data pointers, with a programmable
 * stretch of the access and of the read and write strobes.
 * Assumes the core issues one move request at a time while idle, and that
 * external memory answers within the strobe width programmed.
 */
// Behaviour
// - indexed form low address from working register
// - indexed form high address from port 2
// - pointer form uses selected 16-bit pointer
// - two pointers, select bit 0 at 86h
// - other select bits unused, read zero
// - select 0 primary, 1 secondary pointer
// - fetch machine cycle, then access cycle
// - stretch from timing control bits 2..0
// - move lasts stretch plus two cycles
// - only moves stretched, CPU held meanwhile
// - stretch resets to one
// - strobe 2 clocks, else 4 per step
// - machine cycle is four clock states
// - strobes lengthen with the stretch
`timescale 1ns/1ns
`include "xdata_defines.vh"
module external_data_access_stretch (
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire move_req_i,
   input wire move_write_i,
   input wire move_ptr_i,
   input wire move_reg_i,
   input wire [7:0] move_wdata_i,
   output reg [7:0] move_rdata_o,
   output reg move_done_o,
   output reg cpu_hold_o,
   output reg busy_o,
   output reg [15:0] xaddr_o,
   input wire [7:0] xdata_i,
   output reg [7:0] xdata_o,
   output reg xdata_oe_n_o,
   output reg rd_n_o,
   output reg wr_n_o
);
   // one state per phase; a single counter times both phases
   localparam ST_IDLE = 2'd0;
   localparam ST_FETCH = 2'd1;
   localparam ST_ACCESS = 2'd2;

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   // strobe window in access-phase counts; stretch 0 is the half-width
   // special case, every other step fills whole machine cycles
   function strobe_on;
      input [2:0] s;
      input [4:0] c;
      begin
         if (s == 3'd0) begin
            strobe_on = (c >= `STROBE_START_S0) &&
               (c < `STROBE_START_S0 + `STROBE_CLOCKS_S0);
         end else begin
            strobe_on = (c >= `STROBE_START) &&
               (c < `STROBE_START + {s, 2'b00});
         end
      end
   endfunction

   // last access count: one machine cycle per step plus the basic one
   function [4:0] access_last;
      input [2:0] s;
      begin
         access_last = {s, 2'b00} + `CLOCKS_PER_MCYCLE - 5'd1;
      end
   endfunction

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   reg [15:0] primary_data_pointer;
   reg [15:0] secondary_data_pointer;
   reg pointer_select_bit;
   reg [7:0] access_timing_control;
   reg [7:0] port2_latch;
   reg [1:0] bank;
   reg [1:0] state;
   reg [4:0] cnt;
   reg [2:0] stretch_q;
   reg dir_write;
   reg use_ptr;
   reg reg_idx;
   reg [7:0] wdata_q;

   wire [2:0] stretch_field;
   wire [15:0] sel_pointer;
   wire [7:0] wreg_data;
   wire wreg_we;
   wire [4:0] wreg_raddr;
   wire [4:0] next_cnt;
   wire next_strobe;
   wire bus_busy;

   assign stretch_field = access_timing_control[`STRETCH_MSB:`STRETCH_LSB];
   assign sel_pointer = pointer_select_bit ? secondary_data_pointer
      : primary_data_pointer;
   assign wreg_we = wr_i && (addr_i <= `WREG_SPACE_TOP);
   // only the first two registers of a bank can index a move
   assign wreg_raddr = {bank, 2'b00, reg_idx};
   assign next_cnt = cnt + 5'd1;
   assign next_strobe = strobe_on(stretch_q, next_cnt);
   assign bus_busy = (state != ST_IDLE);

   working_reg_mem u_wregs (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .we_i(wreg_we),
      .waddr_i(addr_i[4:0]),
      .wdata_i(wdata_i),
      .raddr_i(wreg_raddr),
      .rdata_o(wreg_data)
   );

   // ------------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------------
   // pointer bytes follow the select bit at the time of the write
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         primary_data_pointer <= 16'h0000;
         secondary_data_pointer <= 16'h0000;
         pointer_select_bit <= 1'b0;
         access_timing_control <= `TIMING_CTRL_RESET;
         port2_latch <= `PORT2_RESET;
         bank <= 2'b00;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            `ADDR_PTR_SELECT: begin
               pointer_select_bit <= wdata_i[`PTR_SELECT_BIT];
            end
            `ADDR_DP_LOW: begin
               if (pointer_select_bit) begin
                  secondary_data_pointer[7:0] <= wdata_i;
               end else begin
                  primary_data_pointer[7:0] <= wdata_i;
               end
            end
            `ADDR_DP_HIGH: begin
               if (pointer_select_bit) begin
                  secondary_data_pointer[15:8] <= wdata_i;
               end else begin
                  primary_data_pointer[15:8] <= wdata_i;
               end
            end
            `ADDR_TIMING_CTRL: begin
               access_timing_control <= wdata_i;
            end
            `ADDR_PORT2_LATCH: begin
               port2_latch <= wdata_i;
            end
            `ADDR_BANK_SELECT: begin
               bank <= wdata_i[`BANK_MSB:`BANK_LSB];
            end
            default: begin
               bank <= bank;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // register reads, data one cycle after the strobe
   // ------------------------------------------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         if (rd_i) begin
            case (addr_i)
               `ADDR_PTR_SELECT: begin
                  rdata_o <= {7'h00, pointer_select_bit};
               end
               `ADDR_DP_LOW: begin
                  rdata_o <= sel_pointer[7:0];
               end
               `ADDR_DP_HIGH: begin
                  rdata_o <= sel_pointer[15:8];
               end
               `ADDR_TIMING_CTRL: begin
                  rdata_o <= access_timing_control;
               end
               `ADDR_PORT2_LATCH: begin
                  rdata_o <= port2_latch;
               end
               `ADDR_BANK_SELECT: begin
                  rdata_o <= {3'b000, bank, 3'b000};
               end
               `ADDR_STATUS: begin
                  rdata_o <= {6'h00, cpu_hold_o, bus_busy};
               end
               // working registers are write-only here and read as zero
               default: begin
                  rdata_o <= 8'h00;
               end
            endcase
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------------------
   // move sequencer
   // ------------------------------------------------------------------------
   // stretch is latched at the request so a rewrite mid-move cannot
   // tear the strobe timing
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         cnt <= 5'd0;
         stretch_q <= 3'd0;
         dir_write <= 1'b0;
         use_ptr <= 1'b0;
         reg_idx <= 1'b0;
         wdata_q <= 8'h00;
         move_rdata_o <= 8'h00;
         move_done_o <= 1'b0;
         cpu_hold_o <= 1'b0;
         busy_o <= 1'b0;
         xaddr_o <= 16'h0000;
         xdata_o <= 8'h00;
         xdata_oe_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         wr_n_o <= 1'b1;
      end else if (ce_i) begin
         move_done_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               // only taken while idle; a request while busy leaves no sign
               if (move_req_i) begin
                  state <= ST_FETCH;
                  cnt <= 5'd0;
                  stretch_q <= stretch_field;
                  dir_write <= move_write_i;
                  use_ptr <= move_ptr_i;
                  reg_idx <= move_reg_i;
                  wdata_q <= move_wdata_i;
                  busy_o <= 1'b1;
               end
            end
            ST_FETCH: begin
               cnt <= next_cnt;
               if (cnt == `CLOCKS_PER_MCYCLE - 5'd1) begin
                  state <= ST_ACCESS;
                  cnt <= 5'd0;
                  // address and write data launch together at the fetch end,
                  // settled a clock before any strobe falls
                  if (use_ptr) begin
                     xaddr_o <= sel_pointer;
                  end else begin
                     xaddr_o <= {port2_latch, wreg_data};
                  end
                  if (dir_write) begin
                     xdata_o <= wdata_q;
                     xdata_oe_n_o <= 1'b0;
                  end
               end
            end
            ST_ACCESS: begin
               cnt <= next_cnt;
               rd_n_o <= ~(~dir_write & next_strobe);
               wr_n_o <= ~(dir_write & next_strobe);
               // cycles beyond the basic two freeze the CPU
               // (stretch 0 leaves no such cycle, so hold stays low)
               cpu_hold_o <= (next_cnt >= `CLOCKS_PER_MCYCLE - 5'd1) &&
                  (next_cnt < access_last(stretch_q));
               // sample on the last strobe clock, while the far side still drives
               if (!dir_write && !rd_n_o && !next_strobe) begin
                  move_rdata_o <= xdata_i;
               end
               if (cnt == access_last(stretch_q)) begin
                  state <= ST_IDLE;
                  cnt <= 5'd0;
                  rd_n_o <= 1'b1;
                  wr_n_o <= 1'b1;
                  cpu_hold_o <= 1'b0;
                  xdata_oe_n_o <= 1'b1;
                  busy_o <= 1'b0;
                  move_done_o <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // external_data_access_stretch

// File: testbench/xdata_props.sv
/* checker for the external data move block: strobe, length, register relations.
   assumes ce_i high whenever a move or a timing write is under way,
   and one move at a time while idle */
`timescale 1ns/1ns
`include "xdata_defines.vh"
module xdata_props (
   input wire clk_i,
   input wire rstn_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire move_req_i,
   input wire move_done_o,
   input wire cpu_hold_o,
   input wire busy_o,
   input wire xdata_oe_n_o,
   input wire rd_n_o,
   input wire wr_n_o
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   reg [2:0] s;
   reg [2:0] ls;
   reg [5:0] bcnt;
   reg [5:0] hcnt;
   reg [5:0] scnt;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= 3'h1;
         ls <= 3'h1;
         bcnt <= 6'h00;
         hcnt <= 6'h00;
         scnt <= 6'h00;
      end else begin
         if (wr_i && addr_i == `ADDR_TIMING_CTRL)
            s <= wdata_i[2:0];
         // stretch taken at the request edge, later writes wait
         if (move_req_i && !busy_o) begin
            ls <= s;
            bcnt <= 6'h00;
            hcnt <= 6'h00;
         end else begin
            bcnt <= bcnt + {5'h00, busy_o};
            hcnt <= hcnt + {5'h00, cpu_hold_o};
         end
         scnt <= (rd_n_o && wr_n_o) ? 6'h00 : scnt + 6'h01;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   strobe_exclusive_a: assert property (rd_n_o || wr_n_o)
      else $error("both strobes low");
   strobe_width_a: assert property (($rose(rd_n_o) || $rose(wr_n_o)) |->
      scnt == ((ls == 3'h0) ? 6'h02 : {1'b0, ls, 2'b00})) else $error("strobe width");
   move_length_a: assert property (move_done_o |-> bcnt == {{1'b0, ls} + 4'h2, 2'b00})
      else $error("move length");
   hold_length_a: assert property (move_done_o |-> hcnt == {1'b0, ls, 2'b00})
      else $error("hold length");
   fetch_first_a: assert property ($rose(busy_o) |->
      (rd_n_o && wr_n_o && xdata_oe_n_o) [*4]) else $error("strobe in fetch");
   select_zero_a: assert property (rd_i && addr_i == `ADDR_PTR_SELECT |=>
      rdata_o[7:1] == 7'h00) else $error("select upper bits");
   stretch_read_a: assert property (rd_i && addr_i == `ADDR_TIMING_CTRL |=>
      rdata_o == {5'h00, s}) else $error("stretch field");
   write_drive_a: assert property (!wr_n_o |-> !xdata_oe_n_o && busy_o)
      else $error("write strobe without drive");
   read_no_drive_a: assert property (!rd_n_o |-> xdata_oe_n_o && busy_o)
      else $error("read strobe with drive");
endmodule // xdata_props
bind external_data_access_stretch xdata_props xdata_props_i (.clk_i, .rstn_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .move_req_i, .move_done_o, .cpu_hold_o, .busy_o,
   .xdata_oe_n_o, .rd_n_o, .wr_n_o);

// File: testbench/xmem_model.sv
/* external data memory model, 256 bytes on the low address byte.
   assumes active-low strobes; data bus is not held once released */
`timescale 1ns/1ns
module xmem_model (
   input wire clk_i,
   input wire [15:0] xaddr_i,
   input wire [7:0] wdata_i,
   input wire rd_n_i,
   input wire wr_n_i,
   output reg [7:0] rdata_o
);
   reg [7:0] mem [0:255];
   integer k;
   initial begin
      for (k = 0; k < 256; k = k + 1)
         mem[k] = k[7:0] ^ 8'h5A;
      rdata_o = 8'h00;
   end
   always @(posedge clk_i) begin
      // answers one clock into the strobe, well inside its width
      if (!rd_n_i)
         rdata_o <= mem[xaddr_i[7:0]];
      else
         rdata_o <= ~rdata_o;
      if (!wr_n_i)
         mem[xaddr_i[7:0]] <= wdata_i;
   end
endmodule // xmem_model

// File: testbench/testbench.sv
/* self-checking bench for the external data move block.
   assumes the memory model on the far side; ce_i drops only between moves */
`timescale 1ns/1ns
module testbench;
   reg clk_i, rstn_i, ce_i, wr_i, rd_i, move_req_i, move_write_i, move_ptr_i, move_reg_i;
   reg [7:0] addr_i, wdata_i, move_wdata_i;
   wire [7:0] rdata_o, move_rdata_o, xdata_i, xdata_o;
   wire move_done_o, cpu_hold_o, busy_o, xdata_oe_n_o, rd_n_o, wr_n_o;
   wire [15:0] xaddr_o;
   integer error_cnt, n_tests, cyc, i;
   external_data_access_stretch external_data_access_stretch_i (.clk_i, .rstn_i, .ce_i,
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .move_req_i, .move_write_i, .move_ptr_i,
      .move_reg_i, .move_wdata_i, .move_rdata_o, .move_done_o, .cpu_hold_o, .busy_o,
      .xaddr_o, .xdata_i, .xdata_o, .xdata_oe_n_o, .rd_n_o, .wr_n_o);
   xmem_model xmem_model_i (.clk_i, .xaddr_i(xaddr_o), .wdata_i(xdata_o), .rd_n_i(rd_n_o),
      .wr_n_i(wr_n_o), .rdata_o(xdata_i));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task complete_run;
      begin
         if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clk_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clk_i);
         rd_i <= 1'b0;
         #1;
         chk("register read", rdata_o, e);
      end
   endtask
   task mv(input w, input p, input r, input [7:0] d, input [15:0] ea, input [2:0] s);
      reg [15:0] n, sc, hc;
      begin
         @(posedge clk_i);
         move_write_i <= w;
         move_ptr_i <= p;
         move_reg_i <= r;
         move_wdata_i <= d;
         move_req_i <= 1'b1;
         @(posedge clk_i);
         move_req_i <= 1'b0;
         n = 0;
         sc = 0;
         hc = 0;
         #1;
         while (move_done_o !== 1'b1 && n < 16'd60) begin
            sc = sc + (!rd_n_o || !wr_n_o);
            hc = hc + cpu_hold_o;
            @(posedge clk_i);
            #1;
            n = n + 1;
         end
         chk("move cycles", n, (s + 16'd2) * 16'd4);
         chk("strobe clocks", sc, (s == 3'h0) ? 16'd2 : s * 16'd4);
         chk("hold clocks", hc, s * 16'd4);
         chk("address", xaddr_o, ea);
         if (!w)
            chk("read byte", move_rdata_o, d);
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      begin
         rd(8'h8E, 8'h01);
         rd(8'h86, 8'h00);
         rd(8'h82, 8'h00);
         rd(8'h8F, 8'h00);
         rd(8'hA0, 8'hFF);
         rd(8'h90, 8'h00);
      end
   endtask
   task t_select;
      begin
         wr(8'h86, 8'hFF);
         rd(8'h86, 8'h01);
      end
   endtask
   task t_pointers;
      begin
         wr(8'h86, 8'h00);
         wr(8'h82, 8'h34);
         wr(8'h83, 8'h12);
         wr(8'h86, 8'h01);
         wr(8'h82, 8'h78);
         wr(8'h83, 8'h56);
         rd(8'h82, 8'h78);
         mv(1'b0, 1'b1, 1'b0, 8'h22, 16'h5678, 3'h1);
         wr(8'h86, 8'h00);
         rd(8'h83, 8'h12);
         mv(1'b0, 1'b1, 1'b0, 8'h6E, 16'h1234, 3'h1);
      end
   endtask
   task t_indexed;
      begin
         wr(8'hA0, 8'hAB);
         wr(8'hD0, 8'h08);
         wr(8'h09, 8'hCD);
         wr(8'h08, 8'h12);
         rd(8'hD0, 8'h08);
         // a frozen clock enable must swallow this port 2 write
         @(posedge clk_i);
         ce_i <= 1'b0;
         wr(8'hA0, 8'h11);
         ce_i <= 1'b1;
         mv(1'b0, 1'b0, 1'b1, 8'h97, 16'hABCD, 3'h1);
         mv(1'b0, 1'b0, 1'b0, 8'h48, 16'hAB12, 3'h1);
      end
   endtask
   task t_stretch;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wr(8'h8E, i[7:0]);
            rd(8'h8E, i[7:0]);
            mv(1'b0, 1'b1, 1'b0, 8'h6E, 16'h1234, i[2:0]);
         end
      end
   endtask
   task t_write;
      begin
         wr(8'h8E, 8'h00);
         mv(1'b1, 1'b1, 1'b0, 8'h3C, 16'h1234, 3'h0);
         mv(1'b0, 1'b1, 1'b0, 8'h3C, 16'h1234, 3'h0);
      end
   endtask
   task t_rerun;
      begin
         @(posedge clk_i);
         rstn_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         rstn_i <= 1'b1;
         t_reset;
      end
   endtask
   // ---------------------------------------------------------------
   // clock, reset, sequence, timeout
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      {rstn_i, wr_i, rd_i, move_req_i, move_write_i, move_ptr_i, move_reg_i} = 7'h00;
      {addr_i, wdata_i, move_wdata_i} = 24'h0000_00;
      ce_i = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset;
      t_select;
      t_pointers;
      t_indexed;
      t_stretch;
      t_write;
      t_rerun;
      complete_run;
   end
   initial begin
      cyc = 0;
      // whole run needs well under two thousand cycles
      forever begin
         @(posedge clk_i);
         cyc = cyc + 1;
         if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            complete_run;
         end
      end
   end
endmodule // testbench
